/* design/lssc_regs.svh */
`ifndef LSSC_REGS_SVH
`define LSSC_REGS_SVH
// Notes on behaviour
// - bit 17 set reduces inverter current limit during soft-start; reset value 0.
// - read-only bit 16 shows positive gate regulator power-good.
// - bit 15 enables positive gate regulator; resets to 0.
// - bits 14:13 pick positive soft-start: 00 6.78, 10 13.6, 01 27.1, 11 54.3 ms.
// - read-only bit 12 shows negative gate regulator power-good.
// - bit 11 enables negative gate regulator; resets to 0.
// - bits 10:9 pick negative soft-start with the same coding.
// - read-only bit 8 shows auxiliary input above undervoltage lockout.
// - bits 6:0 are offset code N, N steps of 7.8 mV.
// - stand-alone uses default limits and soft-start; sequencing from select inputs.
// - stand-alone keeps offset code at reset value, unchangeable.
// - bit 31 zero writes and reads back; one only reads.
// - read bit 31 returns the direction bit of the previous 32-bit frame.
// - unassigned write positions are discarded.

// ==========================================================
// frame layout
`define LSSC_FRAME_BITS      6'd32
`define LSSC_BIT_DIR         31
`define LSSC_BIT_INV_LIM     17
`define LSSC_BIT_POS_GOOD    16
`define LSSC_BIT_POS_ON      15
`define LSSC_BIT_POS_SS_HI   14
`define LSSC_BIT_POS_SS_LO   13
`define LSSC_BIT_NEG_GOOD    12
`define LSSC_BIT_NEG_ON      11
`define LSSC_BIT_NEG_SS_HI   10
`define LSSC_BIT_NEG_SS_LO   9
`define LSSC_BIT_AUX_OK      8
`define LSSC_BIT_RSV_ONE     7
`define LSSC_OFS_MSB         6
// ==========================================================
// reset values
`define LSSC_RST_INV_LIM     1'b0
`define LSSC_RST_ON          1'b0
`define LSSC_RST_SS          2'h0
`define LSSC_RST_RSV_ONE     1'b1
`define LSSC_RST_OFS         7'h00
`define LSSC_RST_DIR         1'b0
`endif

/* design/lssc_pkg.sv */
package lssc_pkg;
   // soft-start code as {hi, lo}
   typedef logic [1:0] lssc_ss_t;
   typedef logic [6:0] lssc_ofs_t;
   typedef enum logic {LSSC_IDLE, LSSC_SHIFT} lssc_frame_e;
endpackage

/* design/lssc_top.sv */
`timescale 1ns/1ps
`include "lssc_regs.svh"
module lssc_top (
   // clock and reset
   input  wire logic               CLK_I,
   input  wire logic               RESETN_I,
   // serial link pins
   input  wire logic               SPI_CS_N_I,
   input  wire logic               SPI_SCLK_I,
   input  wire logic               SPI_MOSI_I,
   output logic                    SPI_MISO_O,
   output logic                    SPI_MISO_OE_O,
   // analog status
   input  wire logic               POS_GATE_REG_GOOD_I,
   input  wire logic               NEG_GATE_REG_GOOD_I,
   input  wire logic               AUX_INPUT_ABOVE_LOCKOUT_I,
   // mode and sequencing pins
   input  wire logic               STANDALONE_I,
   input  wire logic               SEQUENCE_SELECT_A_I,
   input  wire logic               SEQUENCE_SELECT_B_I,
   // control to analog
   output logic                    INVERTER_STARTUP_LIMIT_REDUCE_O,
   output logic                    POS_GATE_REG_ON_O,
   output lssc_pkg::lssc_ss_t      POS_GATE_SOFTSTART_O,
   output logic                    NEG_GATE_REG_ON_O,
   output lssc_pkg::lssc_ss_t      NEG_GATE_SOFTSTART_O,
   output lssc_pkg::lssc_ofs_t     OFFSET_CODE_O,
   output logic                    SEQ_FROM_PINS_O,
   output logic                    SEQ_SELECT_A_O,
   output logic                    SEQ_SELECT_B_O
);
   import lssc_pkg::*;

   // ==========================================================
   // pin synchronisers
   logic [8:0]  sync1_q;
   logic [8:0]  sync2_q;
   logic        sclk_d1_q;
   logic        cs_n_d1_q;
   logic        cs_n_s;
   logic        sclk_s;
   logic        mosi_s;
   logic        pos_good_s;
   logic        neg_good_s;
   logic        aux_ok_s;
   logic        alone_s;
   logic        sel_a_s;
   logic        sel_b_s;

   always_ff @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         sync1_q <= 9'h100;
         sync2_q <= 9'h100;
      end else begin
         sync1_q <= {SPI_CS_N_I, SPI_SCLK_I, SPI_MOSI_I, POS_GATE_REG_GOOD_I,
                     NEG_GATE_REG_GOOD_I, AUX_INPUT_ABOVE_LOCKOUT_I, STANDALONE_I,
                     SEQUENCE_SELECT_A_I, SEQUENCE_SELECT_B_I};
         sync2_q <= sync1_q;
      end
   end
   // reset pattern: chip select idle high, everything else low
   assign {cs_n_s, sclk_s, mosi_s, pos_good_s, neg_good_s, aux_ok_s, alone_s,
           sel_a_s, sel_b_s} = sync2_q;

   always_ff @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         sclk_d1_q <= 1'b0;
         cs_n_d1_q <= 1'b1;
      end else begin
         sclk_d1_q <= sclk_s;
         cs_n_d1_q <= cs_n_s;
      end
   end

   logic sclk_rise;
   logic sclk_fall;
   logic cs_fall;
   logic cs_rise;
   assign sclk_rise = sclk_s & ~sclk_d1_q;
   assign sclk_fall = ~sclk_s & sclk_d1_q;
   assign cs_fall   = ~cs_n_s & cs_n_d1_q;
   assign cs_rise   = cs_n_s & ~cs_n_d1_q;

   // ==========================================================
   // frame tracking
   lssc_frame_e state_q;
   logic [5:0]  cnt_q;
   logic [31:0] rx_q;
   logic [31:0] tx_q;
   logic        last_dir_q;
   logic        full_frame;
   logic        commit;

   // a frame longer than 32 clocks is treated as broken
   assign full_frame = (state_q == LSSC_SHIFT) && cs_rise && (cnt_q == `LSSC_FRAME_BITS);
   assign commit     = full_frame && (rx_q[`LSSC_BIT_DIR] == 1'b0) && !alone_s;

   always_ff @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         state_q <= LSSC_IDLE;
      end else begin
         case (state_q)
            LSSC_IDLE: begin
               if (cs_fall) begin
                  state_q <= LSSC_SHIFT;
               end
            end
            default: begin
               if (cs_rise) begin
                  state_q <= LSSC_IDLE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         cnt_q <= 6'h00;
         rx_q  <= 32'h0000_0000;
      end else if (cs_fall) begin
         cnt_q <= 6'h00;
      end else if (state_q == LSSC_SHIFT && sclk_rise) begin
         rx_q <= {rx_q[30:0], mosi_s};
         if (cnt_q != 6'h3f) begin
            cnt_q <= cnt_q + 6'h01;
         end
      end
   end

   always_ff @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         last_dir_q <= `LSSC_RST_DIR;
      end else if (full_frame) begin
         last_dir_q <= rx_q[`LSSC_BIT_DIR];
      end
   end

   // ==========================================================
   // stored control fields
   logic      inv_lim_q;
   logic      pos_on_q;
   lssc_ss_t  pos_ss_q;
   logic      neg_on_q;
   lssc_ss_t  neg_ss_q;
   logic      rsv_one_q;
   lssc_ofs_t ofs_q;

   always_ff @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         inv_lim_q <= `LSSC_RST_INV_LIM;
         pos_on_q  <= `LSSC_RST_ON;
         pos_ss_q  <= `LSSC_RST_SS;
         neg_on_q  <= `LSSC_RST_ON;
         neg_ss_q  <= `LSSC_RST_SS;
         rsv_one_q <= `LSSC_RST_RSV_ONE;
         ofs_q     <= `LSSC_RST_OFS;
      end else if (alone_s) begin
         // stand-alone pins the whole word to its reset defaults
         inv_lim_q <= `LSSC_RST_INV_LIM;
         pos_on_q  <= `LSSC_RST_ON;
         pos_ss_q  <= `LSSC_RST_SS;
         neg_on_q  <= `LSSC_RST_ON;
         neg_ss_q  <= `LSSC_RST_SS;
         rsv_one_q <= `LSSC_RST_RSV_ONE;
         ofs_q     <= `LSSC_RST_OFS;
      end else if (commit) begin
         // only assigned positions are kept; the rest of rx_q is dropped
         inv_lim_q <= rx_q[`LSSC_BIT_INV_LIM];
         pos_on_q  <= rx_q[`LSSC_BIT_POS_ON];
         pos_ss_q  <= rx_q[`LSSC_BIT_POS_SS_HI:`LSSC_BIT_POS_SS_LO];
         neg_on_q  <= rx_q[`LSSC_BIT_NEG_ON];
         neg_ss_q  <= rx_q[`LSSC_BIT_NEG_SS_HI:`LSSC_BIT_NEG_SS_LO];
         rsv_one_q <= rx_q[`LSSC_BIT_RSV_ONE];
         ofs_q     <= rx_q[`LSSC_OFS_MSB:0];
      end
   end

   // ==========================================================
   // read word and serial output
   logic [31:0] rd_word;
   always_comb begin
      rd_word                        = 32'h0000_0000;
      rd_word[`LSSC_BIT_DIR]         = last_dir_q;
      rd_word[`LSSC_BIT_INV_LIM]     = inv_lim_q;
      rd_word[`LSSC_BIT_POS_GOOD]    = pos_good_s;
      rd_word[`LSSC_BIT_POS_ON]      = pos_on_q;
      rd_word[`LSSC_BIT_POS_SS_HI:`LSSC_BIT_POS_SS_LO] = pos_ss_q;
      rd_word[`LSSC_BIT_NEG_GOOD]    = neg_good_s;
      rd_word[`LSSC_BIT_NEG_ON]      = neg_on_q;
      rd_word[`LSSC_BIT_NEG_SS_HI:`LSSC_BIT_NEG_SS_LO] = neg_ss_q;
      rd_word[`LSSC_BIT_AUX_OK]      = aux_ok_s;
      rd_word[`LSSC_BIT_RSV_ONE]     = rsv_one_q;
      rd_word[`LSSC_OFS_MSB:0]       = ofs_q;
   end

   // snapshot at chip select fall, msb first, next bit after each falling clock
   always_ff @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         tx_q <= 32'h0000_0000;
      end else if (cs_fall) begin
         tx_q <= rd_word;
      end else if (state_q == LSSC_SHIFT && sclk_fall) begin
         tx_q <= {tx_q[30:0], 1'b0};
      end
   end

   assign SPI_MISO_O    = tx_q[31];
   assign SPI_MISO_OE_O = (state_q == LSSC_SHIFT);

   // ==========================================================
   // outputs to the analog side
   assign INVERTER_STARTUP_LIMIT_REDUCE_O = inv_lim_q;
   assign POS_GATE_REG_ON_O               = pos_on_q;
   assign POS_GATE_SOFTSTART_O            = pos_ss_q;
   assign NEG_GATE_REG_ON_O               = neg_on_q;
   assign NEG_GATE_SOFTSTART_O            = neg_ss_q;
   assign OFFSET_CODE_O                   = ofs_q;
   // in stand-alone the sequencer follows the two select pins
   assign SEQ_FROM_PINS_O                 = alone_s;
   assign SEQ_SELECT_A_O                  = sel_a_s;
   assign SEQ_SELECT_B_O                  = sel_b_s;

   // ==========================================================
   // checks
   inv_lim_load_a : assert property (@(posedge CLK_I) disable iff (!RESETN_I)
      commit |=> INVERTER_STARTUP_LIMIT_REDUCE_O == $past(rx_q[17]))
      else $error("limit bit not taken from frame");

   pos_good_rd_a : assert property (@(posedge CLK_I) disable iff (!RESETN_I)
      cs_fall |=> tx_q[16] == $past(pos_good_s))
      else $error("positive good bit wrong in read word");

   pos_on_hold_a : assert property (@(posedge CLK_I) disable iff (!RESETN_I)
      $rose(POS_GATE_REG_ON_O) |-> $past(commit))
      else $error("positive enable rose without a committed write");

   pos_ss_load_a : assert property (@(posedge CLK_I) disable iff (!RESETN_I)
      commit |=> POS_GATE_SOFTSTART_O == $past(rx_q[14:13]))
      else $error("positive soft-start code wrong");

   neg_good_rd_a : assert property (@(posedge CLK_I) disable iff (!RESETN_I)
      cs_fall |=> tx_q[12] == $past(neg_good_s))
      else $error("negative good bit wrong in read word");

   neg_fields_a : assert property (@(posedge CLK_I) disable iff (!RESETN_I)
      commit |=> NEG_GATE_SOFTSTART_O == $past(rx_q[10:9])
                 && NEG_GATE_REG_ON_O == $past(rx_q[11]))
      else $error("negative regulator fields wrong");

   aux_ok_rd_a : assert property (@(posedge CLK_I) disable iff (!RESETN_I)
      cs_fall |=> tx_q[8] == $past(aux_ok_s))
      else $error("auxiliary supply bit wrong in read word");

   alone_dflt_a : assert property (@(posedge CLK_I) disable iff (!RESETN_I)
      alone_s |=> OFFSET_CODE_O == 7'h00 && !POS_GATE_REG_ON_O
                  && POS_GATE_SOFTSTART_O == 2'h0 && !INVERTER_STARTUP_LIMIT_REDUCE_O)
      else $error("stand-alone did not hold defaults");

   read_only_a : assert property (@(posedge CLK_I) disable iff (!RESETN_I)
      full_frame && rx_q[31] |=> $stable(OFFSET_CODE_O) && $stable(POS_GATE_REG_ON_O))
      else $error("read frame changed the word");

   dir_echo_a : assert property (@(posedge CLK_I) disable iff (!RESETN_I)
      cs_fall |=> tx_q[31] == $past(last_dir_q))
      else $error("direction echo wrong");

   dir_store_a : assert property (@(posedge CLK_I) disable iff (!RESETN_I)
      full_frame |=> last_dir_q == $past(rx_q[31]))
      else $error("direction bit not kept from full frame");

   short_frame_a : assert property (@(posedge CLK_I) disable iff (!RESETN_I)
      cs_rise && cnt_q != 6'd32 && !alone_s |=> $stable(OFFSET_CODE_O)
                                             && $stable(NEG_GATE_REG_ON_O))
      else $error("incomplete frame changed the word");

   pos_on_load_a : assert property (@(posedge CLK_I) disable iff (!RESETN_I)
      commit |=> POS_GATE_REG_ON_O == $past(rx_q[15]))
      else $error("positive enable not taken from frame");

   neg_on_rise_a : assert property (@(posedge CLK_I) disable iff (!RESETN_I)
      $rose(NEG_GATE_REG_ON_O) |-> $past(commit))
      else $error("negative enable rose without a committed write");

   ofs_load_a : assert property (@(posedge CLK_I) disable iff (!RESETN_I)
      commit |=> OFFSET_CODE_O == $past(rx_q[6:0]))
      else $error("offset code not taken from frame");

   rsv_keep_a : assert property (@(posedge CLK_I) disable iff (!RESETN_I)
      commit |=> rsv_one_q == $past(rx_q[7]))
      else $error("reserved bit not taken from frame");

   alone_neg_a : assert property (@(posedge CLK_I) disable iff (!RESETN_I)
      alone_s |=> !NEG_GATE_REG_ON_O && NEG_GATE_SOFTSTART_O == 2'h0)
      else $error("stand-alone did not hold negative defaults");

   oe_on_a : assert property (@(posedge CLK_I) disable iff (!RESETN_I)
      cs_fall |=> SPI_MISO_OE_O)
      else $error("data out not enabled at frame start");

   oe_off_a : assert property (@(posedge CLK_I) disable iff (!RESETN_I)
      cs_rise |=> !SPI_MISO_OE_O)
      else $error("data out still enabled after frame end");

   miso_shift_a : assert property (@(posedge CLK_I) disable iff (!RESETN_I)
      state_q == LSSC_SHIFT && sclk_fall && !cs_fall |=> SPI_MISO_O == $past(tx_q[30]))
      else $error("read word not shifted on clock fall");

   mosi_take_a : assert property (@(posedge CLK_I) disable iff (!RESETN_I)
      state_q == LSSC_SHIFT && sclk_rise && !cs_fall |=> rx_q[0] == $past(mosi_s))
      else $error("data in not taken on clock rise");
endmodule

/* tb/lssc_host_model.sv */
`timescale 1ns/1ps
// =====
// host side master: mode 0, msb first, sclk low between frames
module lssc_host_model (
   input  wire logic clk_i,
   input  wire logic miso_i,
   output logic      cs_n_o,
   output logic      sclk_o,
   output logic      mosi_o
);
   initial begin
      cs_n_o = 1'b1;
      sclk_o = 1'b0;
      mosi_o = 1'b0;
   end
   task automatic wait_clk(input int n);
      repeat (n) @(negedge clk_i);
   endtask
   // mosi moves on sclk fall, miso is taken on sclk rise
   task automatic frame(input logic [31:0] tx, input int nbits, output logic [31:0] rx);
      rx = '0;
      if (!tx[31]) tx[7] = 1'b1;
      cs_n_o = 1'b0;
      for (int i = 0; i < nbits; i++) begin
         mosi_o = tx[31-i];
         wait_clk(i == 0 ? 6 : 4);
         sclk_o = 1'b1;
         rx = {rx[30:0], miso_i};
         wait_clk(4);
         sclk_o = 1'b0;
      end
      wait_clk(4);
      cs_n_o = 1'b1;
      // a released data line must not keep looking valid
      mosi_o = ~mosi_o;
      wait_clk(8);
   endtask
endmodule

/* tb/lssc_top_tb_top.sv */
`timescale 1ns/1ps
module lssc_top_tb_top;
   import lssc_pkg::*;
   logic        clk, rst_n, cs_n, sclk, mosi, miso, miso_oe;
   logic        pg, ng, aux, sa, sel_a, sel_b;
   logic        inv_lim, pos_on, neg_on, seq_pins, seq_a, seq_b;
   lssc_ss_t    pos_ss, neg_ss;
   lssc_ofs_t   ofs;
   logic [31:0] exp_w, rx;
   logic        last_dir;
   int          mismatches, checks_done, oe_cycles;
   lssc_top dut (.CLK_I(clk), .RESETN_I(rst_n), .SPI_CS_N_I(cs_n), .SPI_SCLK_I(sclk),
      .SPI_MOSI_I(mosi), .SPI_MISO_O(miso), .SPI_MISO_OE_O(miso_oe),
      .POS_GATE_REG_GOOD_I(pg), .NEG_GATE_REG_GOOD_I(ng), .AUX_INPUT_ABOVE_LOCKOUT_I(aux),
      .STANDALONE_I(sa), .SEQUENCE_SELECT_A_I(sel_a), .SEQUENCE_SELECT_B_I(sel_b),
      .INVERTER_STARTUP_LIMIT_REDUCE_O(inv_lim), .POS_GATE_REG_ON_O(pos_on),
      .POS_GATE_SOFTSTART_O(pos_ss), .NEG_GATE_REG_ON_O(neg_on), .NEG_GATE_SOFTSTART_O(neg_ss),
      .OFFSET_CODE_O(ofs), .SEQ_FROM_PINS_O(seq_pins), .SEQ_SELECT_A_O(seq_a),
      .SEQ_SELECT_B_O(seq_b));
   lssc_host_model host (.clk_i(clk), .miso_i(miso), .cs_n_o(cs_n), .sclk_o(sclk), .mosi_o(mosi));
   // output enable is counted on the quiet edge, away from the design's updates
   always @(negedge clk) if (miso_oe === 1'b1) oe_cycles++;
   // =====
   // checking
   task automatic check(input logic [31:0] seen, input logic [31:0] want, input string what);
      checks_done++;
      if (seen !== want) begin
         mismatches++;
         $display("mismatch at %0t: %s seen %h want %h", $time, what, seen, want);
      end
   endtask
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic check_outs;
      check({14'h0, inv_lim, 1'b0, pos_on, pos_ss, 1'b0, neg_on, neg_ss, 2'h0, ofs},
            exp_w & 32'h0002_ee7f, "controls");
   endtask
   // read word reflects the stored word and the status pins at frame start
   task automatic do_frame(input logic [31:0] tx, input int nbits, input bit judge);
      logic [31:0] want;
      want = {last_dir, 13'h0, exp_w[17], pg, exp_w[15:13], ng, exp_w[11:9], aux, exp_w[7:0]};
      oe_cycles = 0;
      host.frame(tx, nbits, rx);
      if (judge) check(rx, want, "read word");
      // chip select stays low for 8 clock cycles per bit plus 6 cycles of margin
      check(oe_cycles, 8 * nbits + 6, "enable cycles");
      if (nbits == 32) begin
         last_dir = tx[31];
         if (!tx[31] && !sa) exp_w = (tx & 32'h0002_ee7f) | 32'h80;
      end
      check_outs();
   endtask
   // =====
   // scenarios
   task automatic test_reset;
      check_outs();
      {pg, ng, aux} = 3'b101;
      do_frame(32'hffff_ffff, 32, 1);
      $display("test reset done");
   endtask
   task automatic test_codes;
      for (int i = 0; i < 4; i++) begin
         {pg, ng, aux} = {i[0], ~i[0], i[1]};
         do_frame({1'b0, 13'h1fff, i[0], 1'b1, i[1], i[1:0], 1'b1, ~i[1], 2'(3 - i), 2'b10,
                   7'h7f - 7'(i * 42)}, 32, 1);
         do_frame(32'hffff_ffff, 32, 1);
      end
      $display("test codes done");
   endtask
   task automatic test_short;
      do_frame(32'h0000_0000, 31, 0);
      do_frame(32'h7fff_ffff, 32, 1);
      do_frame(32'h0002_0000, 33 - 2, 0);
      do_frame(32'h8000_0000, 32, 1);
      $display("test short done");
   endtask
   task automatic test_standalone;
      {sa, sel_a, sel_b} = 3'b110;
      host.wait_clk(6);
      exp_w = 32'h80;
      check_outs();
      check({29'h0, seq_pins, seq_a, seq_b}, 32'h6, "sequencing pins");
      do_frame(32'h0002_ee7f, 32, 1);
      {sa, sel_a, sel_b} = 3'b001;
      host.wait_clk(6);
      check({29'h0, seq_pins, seq_a, seq_b}, 32'h1, "sequencing pins");
      check_outs();
      $display("test standalone done");
   endtask
   // =====
   // run
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   initial begin
      repeat (60000) @(posedge clk);
      mismatches++;
      give_verdict();
   end
   initial begin
      {rst_n, pg, ng, aux, sa, sel_a, sel_b} = 7'h0;
      {mismatches, checks_done, last_dir, exp_w} = '0;
      exp_w = 32'h80;
      repeat (4) @(negedge clk);
      rst_n = 1'b1;
      host.wait_clk(4);
      test_reset();
      test_codes();
      test_short();
      test_standalone();
      give_verdict();
   end
endmodule
